// ===== hw/aals_pkg.sv
// Constants, field positions and encodings shared by the accumulator add, logic and shift unit.
package aals_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int ACC_W  = 40;
  localparam int WORD_W = 16;
  localparam int CTRL_W = 8;
  localparam int CNT_W  = 6;

  // ==========================================================================
  // Condition flag bit positions
  // ==========================================================================
  localparam int FLG_C = 0;
  localparam int FLG_V = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_N = 3;
  localparam int FLG_U = 4;
  localparam int FLG_E = 5;
  localparam int FLG_L = 6;
  localparam int FLG_S = 7;

  // ==========================================================================
  // Values after reset
  // ==========================================================================
  localparam logic [ACC_W-1:0]  ACC_RST  = 40'h00_0000_0000;
  localparam logic [CTRL_W-1:0] FLG_RST  = 8'h00;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;

  // ==========================================================================
  // Instruction, operand and register encodings
  // ==========================================================================
  typedef enum logic [2:0] {
    OP_HALVE_ADD        = 3'h0,
    OP_AND_UPPER        = 3'h1,
    OP_AND_CTRL         = 3'h2,
    OP_ARITH_SHIFT_LEFT = 3'h3,
    OP_ARITH_SHIFT_CNT  = 3'h4
  } aals_op_e;

  localparam logic       DEST_A        = 1'b0;
  localparam logic [1:0] AND_SRC_REG   = 2'h0;
  localparam logic [1:0] AND_SRC_SHORT = 2'h1;
  localparam logic [1:0] AND_SRC_LONG  = 2'h2;

  localparam logic [1:0] IN_X0 = 2'h0;
  localparam logic [1:0] IN_X1 = 2'h1;
  localparam logic [1:0] IN_Y0 = 2'h2;

  localparam logic [1:0] CTL_MODE  = 2'h0;
  localparam logic [1:0] CTL_FLAGS = 2'h1;
  localparam logic [1:0] CTL_OPMOD = 2'h2;

  localparam logic [2:0] CNT_X0 = 3'h0;
  localparam logic [2:0] CNT_X1 = 3'h1;
  localparam logic [2:0] CNT_Y0 = 3'h2;
  localparam logic [2:0] CNT_Y1 = 3'h3;
  localparam logic [2:0] CNT_A1 = 3'h4;
  localparam logic [2:0] CNT_B1 = 3'h5;

  localparam logic [2:0] LD_ACC_A = 3'h0;
  localparam logic [2:0] LD_ACC_B = 3'h1;
  localparam logic [2:0] LD_FLAGS = 3'h2;
  localparam logic [2:0] LD_MODE  = 3'h3;
  localparam logic [2:0] LD_OPMOD = 3'h4;
  localparam logic [2:0] LD_EXTOM = 3'h5;

  localparam logic [CNT_W-1:0] MAX_SHIFT = 6'h28;

endpackage : aals_pkg

// ===== hw/aals_shifter.sv
// Left shifter of the accumulator with last-bit-out carry and sign-change overflow.
`timescale 1ns/10ps
module aals_shifter (
  input  wire logic [39:0] operand,
  input  wire logic [5:0]  count,
  output logic      [39:0] result,
  output logic             carryOut,
  output logic             overflow
);

  logic [38:0] signChange;
  logic [5:0]  outIdx;
  logic        countInRange;

  // ==========================================================================
  // Shift and carry
  // ==========================================================================
  assign result       = operand << count;
  assign countInRange = (count != 6'h00) && (count <= aals_pkg::MAX_SHIFT);
  assign outIdx       = aals_pkg::MAX_SHIFT - count;
  // A zero count forces the carry low rather than reporting bit 40.
  assign carryOut     = countInRange ? operand[outIdx] : 1'b0;

  // ==========================================================================
  // Overflow: any bit that passes through position 39 and differs from it
  // ==========================================================================
  genvar i;
  generate
    for (i = 0; i < 39; i++) begin : g_chg
      localparam logic [5:0] DIST = 6'(39 - i);
      assign signChange[i] = (operand[i] ^ operand[39]) && (DIST <= count);
    end
  endgenerate
  assign overflow = |signChange;

endmodule : aals_shifter

// ===== hw/aals_flags.sv
// Standard condition flag evaluation of a 40-bit accumulator result.
`timescale 1ns/10ps
module aals_flags (
  input  wire logic [39:0] result,
  input  wire logic        overflowIn,
  input  wire logic        carryIn,
  input  wire logic [7:0]  flagsIn,
  output logic      [7:0]  flagsOut
);

  logic extInUse;
  logic unnorm;

  assign extInUse = !((&result[39:31]) || !(|result[39:31]));
  assign unnorm   = !(result[31] ^ result[30]);

  // Scaling and limit are sticky, so they only ever set here.
  assign flagsOut[aals_pkg::FLG_S] = flagsIn[aals_pkg::FLG_S] | (result[31] ^ result[30]);
  assign flagsOut[aals_pkg::FLG_L] = flagsIn[aals_pkg::FLG_L] | overflowIn;
  assign flagsOut[aals_pkg::FLG_E] = extInUse;
  assign flagsOut[aals_pkg::FLG_U] = unnorm;
  assign flagsOut[aals_pkg::FLG_N] = result[39];
  assign flagsOut[aals_pkg::FLG_Z] = (result == 40'h00_0000_0000);
  assign flagsOut[aals_pkg::FLG_V] = overflowIn;
  assign flagsOut[aals_pkg::FLG_C] = carryIn;

endmodule : aals_flags

// ===== hw/aals_unit.sv
// Accumulator add, logic and shift unit with its accumulators and control registers.
`timescale 1ns/10ps

// Notes on behaviour
// - Halve-add: shift destination right one keeping sign, add source, store.
// - Halve-add carry always correct; overflow only from the addition.
// - Halve-add source is the other accumulator.
// - Halve-add updates S, L, E, U, N, Z, C by standard definitions.
// - AND touches destination bits 31 to 16 only.
// - AND source: input register, short or long immediate; 16 bits wide.
// - Six-bit short immediate is unsigned and zero extended to 16 bits.
// - Two-bit field picks X0, X1, Y0 or Y1 as AND source.
// - After AND, N equals result bit 31.
// - After AND, Z means bits 31 to 16 are zero; V cleared.
// - AND immediate with control register: eight-bit mask stored back.
// - Two-bit field picks mode, flags, operating mode or extended mode.
// - Flags change only when the flags register is that destination.
// - Each flag is cleared where the matching mask bit is zero.
// - Single left shift: old MSB into carry, zero into LSB.
// - Multi left shift: zero fill, last bit out of 39 into carry.
// - Count from six-bit immediate or low six bits of X0, X1, Y0, Y1, A1 or B1.
// - Zero shift count clears carry.
// - Left shift is 40 bits wide and flags signed overflow.
// - Overflow set when bit 39 changes at any time during the shift.
module aals_unit (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        opValid,
  input  wire logic [2:0]  opCode,
  input  wire logic        destSel,
  input  wire logic        srcAccSel,
  input  wire logic [1:0]  andSrcKind,
  input  wire logic [1:0]  input_register_select,
  input  wire logic [5:0]  shortImm,
  input  wire logic [15:0] longImm,
  input  wire logic [7:0]  ctrlImm,
  input  wire logic [1:0]  control_register_select,
  input  wire logic        countFromReg,
  input  wire logic [5:0]  shiftImm,
  input  wire logic [2:0]  countRegSel,
  input  wire logic [15:0] x0,
  input  wire logic [15:0] x1,
  input  wire logic [15:0] y0,
  input  wire logic [15:0] y1,
  input  wire logic        loadValid,
  input  wire logic [2:0]  loadSel,
  input  wire logic [39:0] loadData,
  output logic      [39:0] accA,
  output logic      [39:0] accB,
  output logic      [7:0]  conditionFlags,
  output logic      [7:0]  modeRegister,
  output logic      [7:0]  operatingModeRegister,
  output logic      [7:0]  extendedOperatingMode,
  output logic             opDone
);

  // ==========================================================================
  // State
  // ==========================================================================
  logic [39:0] accA_r;
  logic [39:0] accB_r;
  logic [7:0]  conditionFlags_r;
  logic [7:0]  modeRegister_r;
  logic [7:0]  operatingModeRegister_r;
  logic [7:0]  extendedOperatingMode_r;
  logic        opDone_r;
  logic [39:0] accA_nxt;
  logic [39:0] accB_nxt;
  logic [7:0]  conditionFlags_nxt;
  logic [7:0]  modeRegister_nxt;
  logic [7:0]  operatingModeRegister_nxt;
  logic [7:0]  extendedOperatingMode_nxt;

  // ==========================================================================
  // Instruction decode
  // ==========================================================================
  logic opHalve;
  logic opAnd;
  logic opAndCtrl;
  logic opShift1;
  logic opShiftN;
  logic accWrite;
  logic opAccepted;

  assign opHalve   = opValid && (opCode == aals_pkg::OP_HALVE_ADD);
  assign opAnd     = opValid && (opCode == aals_pkg::OP_AND_UPPER);
  assign opAndCtrl = opValid && (opCode == aals_pkg::OP_AND_CTRL);
  assign opShift1  = opValid && (opCode == aals_pkg::OP_ARITH_SHIFT_LEFT);
  assign opShiftN  = opValid && (opCode == aals_pkg::OP_ARITH_SHIFT_CNT);
  assign accWrite  = opHalve || opAnd || opShift1 || opShiftN;
  assign opAccepted = accWrite || opAndCtrl;

  logic [39:0] destAcc;
  logic [39:0] otherAcc;

  assign destAcc  = (destSel == aals_pkg::DEST_A) ? accA_r : accB_r;
  assign otherAcc = (destSel == aals_pkg::DEST_A) ? accB_r : accA_r;

  // ==========================================================================
  // Halve and add
  // ==========================================================================
  logic [39:0] halfDest;
  logic [40:0] halveSum;
  logic        halveV;
  logic        halveC;

  assign halfDest = {destAcc[39], destAcc[39:1]};
  assign halveSum = {1'b0, halfDest} + {1'b0, otherAcc};
  assign halveC   = halveSum[40];
  // The halving cannot change the sign, so only the add can overflow.
  assign halveV   = (halfDest[39] == otherAcc[39]) && (halveSum[39] != halfDest[39]);

  // ==========================================================================
  // Logical AND on the upper word
  // ==========================================================================
  logic [15:0] inputReg;
  logic [15:0] andSrc;
  logic [15:0] andUpper;
  logic [39:0] andAcc;

  assign inputReg = (input_register_select == aals_pkg::IN_X0) ? x0 :
                    (input_register_select == aals_pkg::IN_X1) ? x1 :
                    (input_register_select == aals_pkg::IN_Y0) ? y0 : y1;
  assign andSrc   = (andSrcKind == aals_pkg::AND_SRC_SHORT) ? {10'h000, shortImm} :
                    (andSrcKind == aals_pkg::AND_SRC_LONG)  ? longImm : inputReg;
  assign andUpper = destAcc[31:16] & andSrc;
  assign andAcc   = {destAcc[39:32], andUpper, destAcc[15:0]};

  // ==========================================================================
  // Arithmetic left shift
  // ==========================================================================
  logic [15:0] countReg;
  logic [5:0]  shiftCount;
  logic [5:0]  shifterCount;
  logic [39:0] shifterIn;
  logic [39:0] shiftResult;
  logic        shiftC;
  logic        shiftV;

  assign countReg = (countRegSel == aals_pkg::CNT_X0) ? x0 :
                    (countRegSel == aals_pkg::CNT_X1) ? x1 :
                    (countRegSel == aals_pkg::CNT_Y0) ? y0 :
                    (countRegSel == aals_pkg::CNT_Y1) ? y1 :
                    (countRegSel == aals_pkg::CNT_A1) ? accA_r[31:16] :
                    (countRegSel == aals_pkg::CNT_B1) ? accB_r[31:16] : 16'h0000;
  // Only the low six bits count; the rest of the register is ignored.
  assign shiftCount   = countFromReg ? countReg[5:0] : shiftImm;
  assign shifterCount = opShiftN ? shiftCount : 6'h01;
  assign shifterIn    = opShiftN ? (srcAccSel ? accB_r : accA_r) : destAcc;

  aals_shifter aals_shifter_inst (
    .operand  (shifterIn),
    .count    (shifterCount),
    .result   (shiftResult),
    .carryOut (shiftC),
    .overflow (shiftV)
  );

  // ==========================================================================
  // Result and flag selection
  // ==========================================================================
  logic [39:0] accResult;
  logic        arithV;
  logic        arithC;
  logic [7:0]  arithFlags;
  logic [7:0]  andFlags;
  logic [7:0]  ctrlTarget;
  logic [7:0]  ctrlMasked;

  assign accResult = opHalve ? halveSum[39:0] : (opAnd ? andAcc : shiftResult);
  assign arithV    = opHalve ? halveV : shiftV;
  assign arithC    = opHalve ? halveC : shiftC;

  aals_flags aals_flags_inst (
    .result     (accResult),
    .overflowIn (arithV),
    .carryIn    (arithC),
    .flagsIn    (conditionFlags_r),
    .flagsOut   (arithFlags)
  );

  assign andFlags = {arithFlags[aals_pkg::FLG_S], conditionFlags_r[6:4], andUpper[15],
                     (andUpper == 16'h0000), 1'b0, conditionFlags_r[0]};

  assign ctrlTarget = (control_register_select == aals_pkg::CTL_MODE)  ? modeRegister_r :
                      (control_register_select == aals_pkg::CTL_FLAGS) ? conditionFlags_r :
                      (control_register_select == aals_pkg::CTL_OPMOD) ?
                        operatingModeRegister_r : extendedOperatingMode_r;
  assign ctrlMasked = ctrlTarget & ctrlImm;

  // ==========================================================================
  // Next values; an instruction takes precedence over a load in the same cycle
  // ==========================================================================
  logic ctlMode;
  logic ctlFlags;
  logic ctlOpMode;
  logic ctlExtMode;
  logic ldIdle;

  assign ctlMode    = opAndCtrl && (control_register_select == aals_pkg::CTL_MODE);
  assign ctlFlags   = opAndCtrl && (control_register_select == aals_pkg::CTL_FLAGS);
  assign ctlOpMode  = opAndCtrl && (control_register_select == aals_pkg::CTL_OPMOD);
  assign ctlExtMode = opAndCtrl && !ctlMode && !ctlFlags && !ctlOpMode;
  assign ldIdle     = loadValid && !opValid;

  assign accA_nxt = (accWrite && destSel == aals_pkg::DEST_A) ? accResult :
                    (ldIdle && loadSel == aals_pkg::LD_ACC_A) ? loadData : accA_r;
  assign accB_nxt = (accWrite && destSel != aals_pkg::DEST_A) ? accResult :
                    (ldIdle && loadSel == aals_pkg::LD_ACC_B) ? loadData : accB_r;

  assign conditionFlags_nxt =
    opAnd                                   ? andFlags :
    (opHalve || opShift1 || opShiftN)       ? arithFlags :
    ctlFlags                                ? ctrlMasked :
    (ldIdle && loadSel == aals_pkg::LD_FLAGS) ? loadData[7:0] : conditionFlags_r;

  assign modeRegister_nxt = ctlMode ? ctrlMasked :
    (ldIdle && loadSel == aals_pkg::LD_MODE) ? loadData[7:0] : modeRegister_r;
  assign operatingModeRegister_nxt = ctlOpMode ? ctrlMasked :
    (ldIdle && loadSel == aals_pkg::LD_OPMOD) ? loadData[7:0] : operatingModeRegister_r;
  assign extendedOperatingMode_nxt = ctlExtMode ? ctrlMasked :
    (ldIdle && loadSel == aals_pkg::LD_EXTOM) ? loadData[7:0] : extendedOperatingMode_r;

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      accA_r                  <= aals_pkg::ACC_RST;
      accB_r                  <= aals_pkg::ACC_RST;
      conditionFlags_r        <= aals_pkg::FLG_RST;
      modeRegister_r          <= aals_pkg::CTRL_RST;
      operatingModeRegister_r <= aals_pkg::CTRL_RST;
      extendedOperatingMode_r <= aals_pkg::CTRL_RST;
      opDone_r                <= 1'b0;
    end else begin
      accA_r                  <= accA_nxt;
      accB_r                  <= accB_nxt;
      conditionFlags_r        <= conditionFlags_nxt;
      modeRegister_r          <= modeRegister_nxt;
      operatingModeRegister_r <= operatingModeRegister_nxt;
      extendedOperatingMode_r <= extendedOperatingMode_nxt;
      opDone_r                <= opAccepted;
    end
  end

  assign accA                  = accA_r;
  assign accB                  = accB_r;
  assign conditionFlags        = conditionFlags_r;
  assign modeRegister          = modeRegister_r;
  assign operatingModeRegister = operatingModeRegister_r;
  assign extendedOperatingMode = extendedOperatingMode_r;
  assign opDone                = opDone_r;

  // ==========================================================================
  // Checks
  // ==========================================================================
  logic [39:0] expectHalveA;
  logic [39:0] expectHalveB;

  // Computed from the registers independently of the datapath mux chain.
  assign expectHalveA = 40'({accA_r[39], accA_r[39:1]} + accB_r);
  assign expectHalveB = 40'({accB_r[39], accB_r[39:1]} + accA_r);

  AST_HALVE_ADD_A: assert property (@(posedge clk) disable iff (!nrst)
    (opHalve && destSel == aals_pkg::DEST_A) |=> accA_r == $past(expectHalveA))
    else $error("halve-add result into A is wrong");

  AST_HALVE_SRC_OTHER: assert property (@(posedge clk) disable iff (!nrst)
    (opHalve && destSel != aals_pkg::DEST_A) |=> $stable(accA_r))
    else $error("halve-add into B disturbed A");

  AST_AND_KEEP: assert property (@(posedge clk) disable iff (!nrst)
    (opAnd && destSel == aals_pkg::DEST_A) |=>
      (accA_r[39:32] == $past(accA_r[39:32])) && (accA_r[15:0] == $past(accA_r[15:0])))
    else $error("AND changed bits outside 31 to 16");

  AST_AND_FLAGS: assert property (@(posedge clk) disable iff (!nrst)
    (opAnd && destSel == aals_pkg::DEST_A) |=>
      (conditionFlags_r[aals_pkg::FLG_N] == accA_r[31]) &&
      (conditionFlags_r[aals_pkg::FLG_Z] == (accA_r[31:16] == 16'h0000)) &&
      !conditionFlags_r[aals_pkg::FLG_V])
    else $error("AND flags do not match the result");

  AST_CTRL_FLAGS_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    (opAndCtrl && control_register_select != aals_pkg::CTL_FLAGS) |=> $stable(conditionFlags_r))
    else $error("control AND changed the flags");

  AST_CTRL_FLAGS_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
    ctlFlags |=> (conditionFlags_r == ($past(conditionFlags_r) & $past(ctrlImm))))
    else $error("flag mask not applied");

  AST_SHIFT1_CARRY: assert property (@(posedge clk) disable iff (!nrst)
    (opShift1 && destSel == aals_pkg::DEST_A) |=>
      (conditionFlags_r[aals_pkg::FLG_C] == $past(accA_r[39])) && !accA_r[0])
    else $error("single shift carry or fill wrong");

  AST_SHIFT_ZERO_CARRY: assert property (@(posedge clk) disable iff (!nrst)
    (opShiftN && shiftCount == 6'h00) |=> !conditionFlags_r[aals_pkg::FLG_C])
    else $error("zero count left carry set");

  AST_SHIFT1_OVERFLOW: assert property (@(posedge clk) disable iff (!nrst)
    (opShift1 && destSel == aals_pkg::DEST_A) |=>
      conditionFlags_r[aals_pkg::FLG_V] == ($past(accA_r[39]) ^ $past(accA_r[38])))
    else $error("single shift overflow wrong");

  AST_HALVE_ADD_B: assert property (@(posedge clk) disable iff (!nrst)
    (opHalve && destSel != aals_pkg::DEST_A) |=> accB_r == $past(expectHalveB))
    else $error("halve-add result into B is wrong");

  AST_HALVE_SHIFT_NO_V: assert property (@(posedge clk) disable iff (!nrst)
    (opHalve && (destAcc[39] != otherAcc[39])) |=> !conditionFlags_r[aals_pkg::FLG_V])
    else $error("halve-add flagged overflow for operands of unlike sign");

  AST_AND_LONG_B: assert property (@(posedge clk) disable iff (!nrst)
    (opAnd && destSel != aals_pkg::DEST_A && andSrcKind == aals_pkg::AND_SRC_LONG) |=>
      accB_r[31:16] == ($past(accB_r[31:16]) & $past(longImm)))
    else $error("AND with long immediate gave a wrong upper word");

  AST_AND_SHORT_ZERO_EXT: assert property (@(posedge clk) disable iff (!nrst)
    (opAnd && destSel != aals_pkg::DEST_A && andSrcKind == aals_pkg::AND_SRC_SHORT) |=>
      accB_r[31:22] == 10'h000)
    else $error("short immediate was not zero extended");

  AST_CTRL_MODE_MASK: assert property (@(posedge clk) disable iff (!nrst)
    ctlMode |=> modeRegister_r == ($past(modeRegister_r) & $past(ctrlImm)))
    else $error("mode register mask not applied");

  AST_SHIFTN_LAST_CARRY: assert property (@(posedge clk) disable iff (!nrst)
    (opShiftN && srcAccSel && shiftCount == aals_pkg::MAX_SHIFT) |=>
      conditionFlags_r[aals_pkg::FLG_C] == $past(accB_r[0]))
    else $error("full-width shift carry is not the last bit out");

  AST_SHIFTN_OVERFLOW: assert property (@(posedge clk) disable iff (!nrst)
    (opShiftN && shiftCount == 6'h01) |=>
      conditionFlags_r[aals_pkg::FLG_V] == ($past(shifterIn[39]) ^ $past(shifterIn[38])))
    else $error("one-place shift overflow wrong");

  AST_ONE_CYCLE: assert property (@(posedge clk) disable iff (!nrst)
    opAccepted |=> opDone_r ##1 (opDone_r == $past(opAccepted)))
    else $error("instruction did not complete in one cycle");

endmodule : aals_unit

// ===== bench/aals_unit_bench.sv
// Self-checking bench of the accumulator add, logic and shift unit.
`timescale 1ns/10ps
module aals_unit_bench;
  logic        clk, nrst, opValid, destSel, srcAccSel, countFromReg, loadValid, opDone;
  logic [2:0]  opCode, countRegSel, loadSel;
  logic [1:0]  andSrcKind, inSel, ctlSel;
  logic [5:0]  shortImm, shiftImm;
  logic [15:0] longImm;
  logic [15:0] xv [4];
  logic [7:0]  ctrlImm, flags, modeReg, opModeReg, extModeReg;
  logic [39:0] loadData, accA, accB;
  logic [39:0] mAcc [2];
  logic [7:0]  mCtl [4];
  int          nErrors, checksDone, cycles;

  aals_unit aals_unit_inst (.clk(clk), .nrst(nrst), .opValid(opValid), .opCode(opCode),
    .destSel(destSel), .srcAccSel(srcAccSel), .andSrcKind(andSrcKind),
    .input_register_select(inSel), .shortImm(shortImm), .longImm(longImm),
    .ctrlImm(ctrlImm), .control_register_select(ctlSel), .countFromReg(countFromReg),
    .shiftImm(shiftImm), .countRegSel(countRegSel), .x0(xv[0]), .x1(xv[1]), .y0(xv[2]),
    .y1(xv[3]), .loadValid(loadValid), .loadSel(loadSel), .loadData(loadData),
    .accA(accA), .accB(accB), .conditionFlags(flags), .modeRegister(modeReg),
    .operatingModeRegister(opModeReg), .extendedOperatingMode(extModeReg), .opDone(opDone));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ==========================================================================
  // Checking and access tasks
  // ==========================================================================
  task automatic wrapUp;
    if (nErrors == 0 && checksDone > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrapUp

  // A hung run is cut short well beyond the hundred or so cycles the tests need.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      nErrors++;
      wrapUp();
    end
  end

  task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nErrors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cmpAll;
    chk("accA", accA, mAcc[0]);
    chk("accB", accB, mAcc[1]);
    chk("flags", {32'h0, flags}, {32'h0, mCtl[1]});
    chk("mode", {32'h0, modeReg}, {32'h0, mCtl[0]});
    chk("opmode", {32'h0, opModeReg}, {32'h0, mCtl[2]});
    chk("extmode", {32'h0, extModeReg}, {32'h0, mCtl[3]});
  endtask : cmpAll

  task automatic load(input logic [2:0] sel, input logic [39:0] d);
    @(negedge clk);
    loadValid = 1'b1;
    loadSel   = sel;
    loadData  = d;
    @(negedge clk);
    loadValid = 1'b0;
    if (sel < 3'h2) mAcc[sel[0]] = d;
    else mCtl[(sel == 3'h2) ? 1 : (sel == 3'h3) ? 0 : int'(sel) - 2] = d[7:0];
  endtask : load

  // Results must be visible one cycle after the instruction is presented.
  task automatic op(input logic [2:0] code);
    @(negedge clk);
    opValid = 1'b1;
    opCode  = code;
    @(negedge clk);
    opValid = 1'b0;
    chk("opDone", {39'h0, opDone}, 40'h1);
    cmpAll();
  endtask : op

  function automatic logic [7:0] stdFlags(input logic [39:0] r, input logic v, input logic c);
    return {mCtl[1][7] | (r[31] ^ r[30]), mCtl[1][6] | v, ~((&r[39:31]) | ~(|r[39:31])),
            ~(r[31] ^ r[30]), r[39], r == 40'h0, v, c};
  endfunction : stdFlags

  task automatic halve(input logic d);
    logic [39:0] h;
    logic [39:0] s;
    logic [40:0] sum;
    h = {mAcc[d][39], mAcc[d][39:1]};
    s = mAcc[!d];
    sum = {1'b0, h} + {1'b0, s};
    mCtl[1] = stdFlags(sum[39:0], (h[39] == s[39]) && (sum[39] != h[39]), sum[40]);
    mAcc[d] = sum[39:0];
    destSel = d;
    op(3'h0);
  endtask : halve

  task automatic andUp(input logic d, input logic [1:0] kind, input logic [15:0] src);
    logic [39:0] r;
    r = mAcc[d];
    r[31:16] = r[31:16] & src;
    mCtl[1] = {mCtl[1][7] | (r[31] ^ r[30]), mCtl[1][6:4], r[31], r[31:16] == 16'h0,
               1'b0, mCtl[1][0]};
    mAcc[d] = r;
    destSel = d;
    andSrcKind = kind;
    op(3'h1);
  endtask : andUp

  task automatic shl(input logic d, input logic s, input logic [5:0] n,
                     input logic [2:0] code, input logic fromReg);
    logic [39:0] o;
    logic        v;
    o = mAcc[s];
    v = 1'b0;
    for (int i = 1; i <= int'(n) && i <= 39; i++) if (o[39-i] != o[39]) v = 1'b1;
    mCtl[1] = stdFlags(o << n, v, (n == 6'h0) ? 1'b0 : o[40-int'(n)]);
    mAcc[d] = o << n;
    destSel = d;
    srcAccSel = s;
    countFromReg = fromReg;
    shiftImm = fromReg ? ~n : n;
    op(code);
  endtask : shl

  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial begin
    {nrst, opValid, destSel, srcAccSel, countFromReg, loadValid, opCode, countRegSel} = '0;
    {loadSel, andSrcKind, inSel, ctlSel, shortImm, shiftImm, longImm, ctrlImm} = '0;
    loadData = 40'h0;
    xv = '{16'hF0E5, 16'h0FC8, 16'h8001, 16'h0000};
    mAcc = '{40'h0, 40'h0};
    mCtl = '{8'h00, 8'h00, 8'h00, 8'h00};
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    cmpAll();
    load(3'h0, 40'h7F_FFFF_FFFE);
    load(3'h1, 40'h7F_0000_0000);
    halve(1'b0);
    halve(1'b1);
    load(3'h0, 40'hFF_8000_0003);
    halve(1'b1);
    load(3'h0, 40'h12_FFFF_5678);
    load(3'h2, 40'h71);
    for (int i = 0; i < 4; i++) begin
      inSel = 2'(i);
      andUp(1'b0, 2'h0, xv[i]);
    end
    shortImm = 6'h3F;
    andUp(1'b1, 2'h1, 16'h003F);
    longImm = 16'hC000;
    andUp(1'b1, 2'h2, 16'hC000);
    for (int i = 2; i < 6; i++) load(3'(i), 40'hFF);
    for (int i = 0; i < 4; i++) begin
      ctlSel = 2'(i);
      ctrlImm = 8'hA5 ^ 8'(i);
      mCtl[i] = mCtl[i] & ctrlImm;
      op(3'h2);
    end
    load(3'h0, 40'hC0_0000_0001);
    shl(1'b0, 1'b0, 6'h01, 3'h3, 1'b0);
    load(3'h1, 40'h40_8000_00FF);
    foreach (xv[i]) shl(1'b0, 1'b1, 6'(i * 13), 3'h4, 1'b0);
    shl(1'b0, 1'b1, 6'h28, 3'h4, 1'b0);
    load(3'h0, 40'h00_0027_0003);
    for (int i = 0; i < 6; i++) begin
      countRegSel = 3'(i);
      shl(i == 5 ? 1'b0 : 1'b1, i == 5 ? 1'b1 : 1'b0,
          i < 4 ? xv[i][5:0] : mAcc[i-4][21:16], 3'h4, 1'b1);
    end
    // An undefined opcode must do nothing, and it still blocks a load in the same cycle.
    @(negedge clk);
    {opValid, opCode, loadValid, loadSel, loadData} = {1'b1, 3'h7, 1'b1, 3'h0, 40'h1};
    @(negedge clk);
    {opValid, loadValid} = 2'b00;
    chk("opDone", {39'h0, opDone}, 40'h0);
    cmpAll();
    wrapUp();
  end
endmodule : aals_unit_bench
